//--- include/ifd_pkg.sv
// Purpose: Shared constants and types for the instruction format decoder.
// Assumes: 24-bit program words, 8-bit opcode in the top bits.
// Notes: Opcode group ranges are a plain split of the opcode space.
package ifd_pkg;
    localparam int WORD_W = 24;
    localparam int OPC_W = 8;
    localparam int OPC_LSB = 16;
    localparam int REG_W = 4;
    localparam int MODE_W = 3;
    localparam int FILE_W = 13;
    localparam int LIT_W = 16;
    localparam int ADDR_W = 23;
    // Opcode group boundaries (first opcode of the other four groups, last opcode of the control group).
    localparam logic [7:0] OPC_BIT_FIRST = 8'hA0;
    localparam logic [7:0] OPC_LIT_FIRST = 8'h20;
    localparam logic [7:0] OPC_DSP_FIRST = 8'hC0;
    localparam logic [7:0] OPC_WB_FIRST = 8'h40;
    localparam logic [7:0] OPC_CTL_LAST = 8'h1F;
    localparam logic [7:0] OPC_NOP = 8'h00;
    // Double-word opcodes: call, goto, move double.
    localparam logic [7:0] OPC_DW_CALL = 8'h02;
    localparam logic [7:0] OPC_DW_GOTO = 8'h04;
    localparam logic [7:0] OPC_DW_MOVD = 8'h08;
    localparam logic [7:0] OPC_TBLRD = 8'h0A;
    localparam logic [7:0] OPC_TBLWR = 8'h0B;
    localparam logic [7:0] OPC_MAC = 8'hC0;
    // Field positions inside a single word.
    localparam int WD_LSB = 7;
    localparam int WS_LSB = 0;
    localparam int WB_LSB = 11;
    localparam int WD_MODE_LSB = 4;
    localparam int FILE_DIR_BIT = 13;
    localparam int BIT_IND_BIT = 15;
    localparam int LIT_DST_BIT = 15;
    localparam int ACC_SEL_BIT = 15;
    localparam int SHIFT_LIT_BIT = 14;
    localparam int TBL_MODE_LSB = 12;
    localparam int XPF_LSB = 6;
    localparam int YPF_LSB = 2;
    localparam int AWB_LSB = 0;
    localparam int MUL_LSB = 10;
    localparam logic [1:0] TWO_CYC = 2'h2;
    localparam logic [1:0] THREE_CYC = 2'h3;

    typedef enum logic [4:0] {
        GRP_WORD = 5'h01,
        GRP_BIT = 5'h02,
        GRP_LIT = 5'h04,
        GRP_DSP = 5'h08,
        GRP_CTL = 5'h10
    } ifd_group_e;

    typedef struct packed {
        logic [WORD_W-1:0] word;
        logic valid;
        logic cond_true;
        logic pc_change;
        logic psv_read;
    } ifd_fetch_s;

    typedef struct packed {
        ifd_group_e group;
        logic [OPC_W-1:0] opcode;
        logic [REG_W-1:0] base_working_register;
        logic [REG_W-1:0] source_working_register;
        logic [MODE_W-1:0] source_mode;
        logic [REG_W-1:0] destination_working_register;
        logic [MODE_W-1:0] destination_mode;
        logic [FILE_W-1:0] file_addr;
        logic file_to_file_op_default_working_register;
        logic [REG_W-1:0] bit_pos;
        logic bit_indirect;
        logic [LIT_W-1:0] literal;
        logic lit_to_file;
        logic has_dest;
        logic acc_b;
        logic multiply_accumulate_class;
        logic [2:0] mul_pair;
        logic [3:0] x_prefetch;
        logic [1:0] x_dest;
        logic [3:0] y_prefetch;
        logic [1:0] y_dest;
        logic [1:0] acc_writeback;
        logic [REG_W-1:0] shift_amount_register;
        logic shift_literal;
        logic [ADDR_W-1:0] prog_addr;
        logic [1:0] tbl_mode;
        logic double_word;
        logic [1:0] cycles;
    } ifd_decode_s;
endpackage

//--- rtl/ifd_decoder.sv
// Purpose: Splits program words into opcode and operand fields by group.
// Assumes: One word is offered per valid cycle; hold input while READY low.
// Notes: Extra cycles of multi-cycle single-word instructions appear as NOP slots.
// Operation
// - Nearly all instructions are one 24-bit word; three take two words.
// - Single word splits into 8-bit opcode and operand bits.
// - Opcodes fall into five groups, each with its own field layout.
// - Working-register word ops decode base, source and destination.
// - File-register word ops decode file address and destination selector.
// - Bit ops address register or file; bit from literal or base register.
// - Literal moves load an immediate into working or file register.
// - Literal arithmetic uses base and literal; destination field optional.
// - Multiply-accumulate decodes accumulator, multipliers, prefetches, write-back.
// - Other signal ops decode accumulator, operand and shift source.
// - Control ops decode a program address or a table mode.
// - Double words span 48 bits; second word top 8 bits zero.
// - A lone second word executes as a no-operation.
// - Double-word instructions take two cycles.
// - Single word takes one cycle unless condition, branch, visibility read or table read.
// - Taken skip takes two cycles, or three over a double word.
`timescale 1ns/10ps
`default_nettype none
module ifd_decoder (
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RST_B,
    // Fetch side.
    input wire ifd_pkg::ifd_fetch_s FETCH,
    input wire logic NEXT_IS_DOUBLE,
    output logic READY,
    // Execute side.
    output ifd_pkg::ifd_decode_s DECODE,
    output logic DECODE_VALID,
    output logic NOP_SLOT,
    output logic SECOND_WORD_BAD
);
    typedef struct packed {
        ifd_pkg::ifd_decode_s dec;
        logic dec_valid;
        logic nop_slot;
        logic bad2;
        logic await_second;
        logic [1:0] remain;
    } ifd_state_s;

    ifd_state_s st_r;
    ifd_state_s st_nxt;
    ifd_pkg::ifd_decode_s d;
    logic [7:0] opc;
    logic [23:0] w;
    logic dw;
    logic skip_taken;

    ////////////////////////////////////////////////////////////////////
    // Field decode of a first word.
    always_comb begin
        w = FETCH.word;
        opc = w[ifd_pkg::OPC_LSB +: ifd_pkg::OPC_W];
        d = '0;
        d.opcode = opc;
        dw = (opc == ifd_pkg::OPC_DW_CALL) || (opc == ifd_pkg::OPC_DW_GOTO) ||
            (opc == ifd_pkg::OPC_DW_MOVD);
        // Group selection by opcode range.
        if (opc <= ifd_pkg::OPC_CTL_LAST) begin
            d.group = ifd_pkg::GRP_CTL;
        end else if (opc < ifd_pkg::OPC_WB_FIRST) begin
            d.group = ifd_pkg::GRP_LIT;
        end else if (opc < ifd_pkg::OPC_BIT_FIRST) begin
            d.group = ifd_pkg::GRP_WORD;
        end else if (opc < ifd_pkg::OPC_DSP_FIRST) begin
            d.group = ifd_pkg::GRP_BIT;
        end else begin
            d.group = ifd_pkg::GRP_DSP;
        end
        unique case (d.group)
            ifd_pkg::GRP_WORD: begin
                if (opc[0]) begin
                    d.file_addr = w[ifd_pkg::FILE_W-1:0];
                    d.file_to_file_op_default_working_register =
                        w[ifd_pkg::FILE_DIR_BIT];
                end else begin
                    d.base_working_register = w[ifd_pkg::WB_LSB +: 4];
                    d.source_working_register = w[ifd_pkg::WS_LSB +: 4];
                    d.source_mode = w[ifd_pkg::WD_MODE_LSB +: 3];
                    d.destination_working_register = w[ifd_pkg::WD_LSB +: 4];
                    d.destination_mode = w[ifd_pkg::WD_MODE_LSB +: 3];
                    d.has_dest = 1'b1;
                end
            end
            ifd_pkg::GRP_BIT: begin
                d.bit_indirect = w[ifd_pkg::BIT_IND_BIT];
                d.base_working_register = w[ifd_pkg::WB_LSB +: 4];
                d.bit_pos = w[ifd_pkg::WB_LSB +: 4];
                if (opc[0]) begin
                    d.file_addr = w[ifd_pkg::FILE_W-1:0];
                end else begin
                    d.source_working_register = w[ifd_pkg::WS_LSB +: 4];
                    d.source_mode = w[ifd_pkg::WD_MODE_LSB +: 3];
                end
            end
            ifd_pkg::GRP_LIT: begin
                if (opc[0]) begin
                    d.literal = w[15:0];
                    d.lit_to_file = w[ifd_pkg::LIT_DST_BIT];
                    d.file_addr = w[ifd_pkg::FILE_W-1:0];
                    d.base_working_register = w[3:0];
                end else begin
                    d.base_working_register = w[ifd_pkg::WB_LSB +: 4];
                    d.literal = {11'h000, w[4:0]};
                    d.has_dest = w[ifd_pkg::LIT_DST_BIT];
                    d.destination_working_register = d.has_dest ?
                        w[ifd_pkg::WD_LSB +: 4] : d.base_working_register;
                end
            end
            ifd_pkg::GRP_DSP: begin
                d.acc_b = w[ifd_pkg::ACC_SEL_BIT];
                if (opc[7:4] == ifd_pkg::OPC_MAC[7:4]) begin
                    d.multiply_accumulate_class = 1'b1;
                    d.mul_pair = w[ifd_pkg::MUL_LSB +: 3];
                    d.x_prefetch = w[ifd_pkg::XPF_LSB +: 4];
                    d.x_dest = w[13:12];
                    d.y_prefetch = {2'h0, w[ifd_pkg::YPF_LSB +: 2]};
                    d.y_dest = w[5:4];
                    d.acc_writeback = w[ifd_pkg::AWB_LSB +: 2];
                end else begin
                    d.source_working_register = w[ifd_pkg::WS_LSB +: 4];
                    d.source_mode = w[ifd_pkg::WD_MODE_LSB +: 3];
                    d.shift_literal = w[ifd_pkg::SHIFT_LIT_BIT];
                    d.shift_amount_register = w[ifd_pkg::WD_LSB +: 4];
                    d.literal = {10'h000, w[12:7]};
                end
            end
            ifd_pkg::GRP_CTL: begin
                d.prog_addr = {7'h00, w[15:0]};
                d.tbl_mode = w[ifd_pkg::TBL_MODE_LSB +: 2];
            end
        endcase
        d.double_word = dw;
        skip_taken = FETCH.cond_true;
        // Cycle count for the instruction.
        if (dw) begin
            d.cycles = ifd_pkg::TWO_CYC;
        end else if (skip_taken && NEXT_IS_DOUBLE) begin
            d.cycles = ifd_pkg::THREE_CYC;
        end else if (skip_taken || FETCH.pc_change || FETCH.psv_read ||
            opc == ifd_pkg::OPC_TBLRD) begin
            d.cycles = ifd_pkg::TWO_CYC;
        end else begin
            d.cycles = 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencing of words and NOP slots.
    always_comb begin
        st_nxt = st_r;
        st_nxt.dec_valid = 1'b0;
        st_nxt.nop_slot = 1'b0;
        st_nxt.bad2 = 1'b0;
        if (st_r.remain != 2'h0) begin
            st_nxt.remain = st_r.remain - 2'h1;
            st_nxt.nop_slot = 1'b1;
        end else if (FETCH.valid) begin
            if (st_r.await_second) begin
                st_nxt.await_second = 1'b0;
                st_nxt.dec.prog_addr = {w[6:0], st_r.dec.prog_addr[15:0]};
                st_nxt.dec.literal = w[15:0];
                st_nxt.bad2 = (w[23:16] != 8'h00);
                st_nxt.dec_valid = 1'b1;
                st_nxt.remain = 2'h0;
            end else if (d.double_word) begin
                st_nxt.dec = d;
                st_nxt.await_second = 1'b1;
                st_nxt.remain = 2'h0;
            end else begin
                st_nxt.dec = d;
                st_nxt.dec_valid = 1'b1;
                st_nxt.remain = d.cycles - 2'h1;
            end
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign READY = (st_r.remain == 2'h0);
    assign DECODE = st_r.dec;
    assign DECODE_VALID = st_r.dec_valid;
    assign NOP_SLOT = st_r.nop_slot;
    assign SECOND_WORD_BAD = st_r.bad2;

    ////////////////////////////////////////////////////////////////////
    // Checks.
    sequence s_single_taken;
        READY && FETCH.valid && !st_r.await_second && !d.double_word;
    endsequence

    AST_DW_WAITS: assert property (@(posedge CLOCK) disable iff (!RST_B)
        READY && FETCH.valid && !st_r.await_second && d.double_word
        |=> st_r.await_second && !DECODE_VALID)
        else $error("double word did not wait for its second word");
    AST_SKIP3: assert property (@(posedge CLOCK) disable iff (!RST_B)
        s_single_taken and (FETCH.cond_true && NEXT_IS_DOUBLE)
        |=> DECODE_VALID ##1 NOP_SLOT [*2])
        else $error("skip over double word did not take three cycles");
    AST_SKIP2: assert property (@(posedge CLOCK) disable iff (!RST_B)
        s_single_taken and (FETCH.cond_true && !NEXT_IS_DOUBLE)
        |=> DECODE_VALID ##1 NOP_SLOT ##1 READY)
        else $error("skip over single word did not take two cycles");
    AST_ONE_CYC: assert property (@(posedge CLOCK) disable iff (!RST_B)
        s_single_taken and (d.cycles == 2'h1) |=> DECODE_VALID && READY)
        else $error("single cycle instruction stalled");
    AST_BRANCH: assert property (@(posedge CLOCK) disable iff (!RST_B)
        s_single_taken and FETCH.pc_change |=> ##1 NOP_SLOT)
        else $error("program counter change gave no NOP slot");
    AST_BAD2: assert property (@(posedge CLOCK) disable iff (!RST_B)
        READY && FETCH.valid && st_r.await_second
        |=> SECOND_WORD_BAD == ($past(FETCH.word[23:16]) != 8'h00))
        else $error("second word top byte check wrong");
    AST_OPCODE: assert property (@(posedge CLOCK) disable iff (!RST_B)
        s_single_taken |=> DECODE.opcode == $past(FETCH.word[23:16]))
        else $error("opcode not taken from the top byte");
    AST_LONE_NOP: assert property (@(posedge CLOCK) disable iff (!RST_B)
        s_single_taken and (FETCH.word[23:16] == ifd_pkg::OPC_NOP)
        |=> DECODE.group == ifd_pkg::GRP_CTL && DECODE_VALID)
        else $error("lone second word not run as a NOP");
    AST_NOSLOT_IDLE: assert property (@(posedge CLOCK) disable iff (!RST_B)
        NOP_SLOT |-> !DECODE_VALID)
        else $error("NOP slot overlaps a decoded instruction");
endmodule
`default_nettype wire

//--- test/ifd_decoder_bench.sv
// Purpose: Self-checking bench for the instruction format decoder.
// Assumes: Single-word cycle count encodes as 1; NOP_SLOT counts extras.
// Notes: Each scenario is a task that drives words and judges the decode.
`timescale 1ns/10ps
`default_nettype none
module ifd_decoder_bench;
    logic CLOCK = 1'b0;
    logic RST_B = 1'b0;
    ifd_pkg::ifd_fetch_s fetch = '0;
    logic next_dbl = 1'b0;
    logic ready;
    logic dec_valid;
    logic nop_slot;
    logic bad;
    ifd_pkg::ifd_decode_s dec;
    int n_errors = 0;
    int checks_done = 0;
    int nops = 0;
    logic bad_seen = 1'b0;

    ifd_decoder u_ifd_decoder (
        .CLOCK(CLOCK),
        .RST_B(RST_B),
        .FETCH(fetch),
        .NEXT_IS_DOUBLE(next_dbl),
        .READY(ready),
        .DECODE(dec),
        .DECODE_VALID(dec_valid),
        .NOP_SLOT(nop_slot),
        .SECOND_WORD_BAD(bad)
    );

    always #5 CLOCK = ~CLOCK;

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Offers one word and holds it until the edge that takes it.
    task automatic send(input logic [23:0] w, input logic [2:0] fl,
                        input logic nd);
        @(posedge CLOCK);
        fetch <= {w, 1'b1, fl};
        next_dbl <= nd;
        #1;
        chk(ready, 1'b1);
        @(posedge CLOCK);
        fetch.valid <= 1'b0;
    endtask

    // Waits for the decode pulse, then counts inserted slots.
    task automatic collect;
        int k;
        nops = 0;
        #1;
        for (k = 0; k < 4 && dec_valid !== 1'b1; k++) begin
            @(posedge CLOCK);
            #1;
        end
        if (dec_valid !== 1'b1) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, dec_valid, 1'b1);
            test_done();
        end
        bad_seen = bad;
        for (k = 0; k < 5; k++) begin
            if (nop_slot === 1'b1) begin
                nops++;
            end
            @(posedge CLOCK);
            #1;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Opcodes either side of each group boundary, plus 10 and D0, single cycle each.
    task automatic t_groups;
        logic [7:0] ops [10] = '{8'h10, 8'h1F, 8'h20, 8'h3F, 8'h40,
                                 8'h9F, 8'hA0, 8'hBF, 8'hC0, 8'hD0};
        ifd_pkg::ifd_group_e grp [10] = '{ifd_pkg::GRP_CTL,
            ifd_pkg::GRP_CTL, ifd_pkg::GRP_LIT, ifd_pkg::GRP_LIT,
            ifd_pkg::GRP_WORD, ifd_pkg::GRP_WORD, ifd_pkg::GRP_BIT,
            ifd_pkg::GRP_BIT, ifd_pkg::GRP_DSP, ifd_pkg::GRP_DSP};
        for (int i = 0; i < 10; i++) begin
            send({ops[i], 16'h2C35}, 3'b000, 1'b0);
            collect();
            chk(dec.opcode, ops[i]);
            chk(dec.group, grp[i]);
            chk(dec.multiply_accumulate_class, ops[i][7:4] == 4'hC);
            chk(dec.double_word, 1'b0);
            chk(nops, 0);
        end
    endtask

    // Condition, skip, branch, visibility read and table read.
    task automatic t_multi;
        logic [23:0] w [5] = '{24'h402C35, 24'h402C35, 24'h402C35,
                               24'h402C35, 24'h0A1234};
        logic [2:0] fl [5] = '{3'b100, 3'b100, 3'b010, 3'b001, 3'b000};
        logic nd [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        logic [1:0] cy [5] = '{ifd_pkg::TWO_CYC, ifd_pkg::THREE_CYC,
            ifd_pkg::TWO_CYC, ifd_pkg::TWO_CYC, ifd_pkg::TWO_CYC};
        for (int i = 0; i < 5; i++) begin
            send(w[i], fl[i], nd[i]);
            collect();
            chk(dec.cycles, cy[i]);
            chk(nops, cy[i] - 1);
        end
    endtask

    // Each double-word opcode, with a good and a bad second word.
    task automatic t_double;
        logic [7:0] ops [3] = '{8'h02, 8'h04, 8'h08};
        logic [23:0] sw;
        for (int i = 0; i < 3; i++) begin
            for (int b = 0; b < 2; b++) begin
                send({ops[i], 16'h1357}, 3'b000, 1'b0);
                #1;
                chk(dec_valid, 1'b0);
                sw = {(b == 1) ? 8'h80 : 8'h00, 16'h6A5B + 16'(i)};
                send(sw, 3'b000, 1'b0);
                collect();
                chk(dec.opcode, ops[i]);
                chk(dec.double_word, 1'b1);
                chk(dec.cycles, ifd_pkg::TWO_CYC);
                chk(dec.prog_addr[22:16], sw[6:0]);
                chk(dec.literal, sw[15:0]);
                chk(bad_seen, b[0]);
            end
        end
    endtask

    // A second word offered on its own runs as a no-operation.
    task automatic t_lone;
        send(24'h001A2B, 3'b000, 1'b0);
        collect();
        chk(dec.opcode, ifd_pkg::OPC_NOP);
        chk(dec.group, ifd_pkg::GRP_CTL);
        chk(dec.double_word, 1'b0);
        chk(bad_seen, 1'b0);
        chk(nops, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge CLOCK);
        RST_B <= 1'b1;
        #1;
        chk(ready, 1'b1);
        t_groups();
        t_multi();
        t_double();
        t_lone();
        test_done();
    end
endmodule
`default_nettype wire
